// file: otm_pkg.sv
// Constants shared by the overtravel and emergency stop monitor.
// Assumes an 8-bit register port and five axes; offsets are word indices.
package otm_pkg;

  localparam int OTM_ADDR_W = 4;
  localparam int OTM_DATA_W = 8;
  localparam int OTM_AXES   = 5;

  // Register offsets
  localparam logic [3:0] OFF_STROKE_CFG = 4'h0;
  localparam logic [3:0] OFF_MODE_CFG   = 4'h1;
  localparam logic [3:0] OFF_LIMIT_CFG  = 4'h2;
  localparam logic [3:0] OFF_SWITCH_CFG = 4'h3;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_MASK   = 4'h5;
  localparam logic [3:0] OFF_ALARM_POS  = 4'h6;
  localparam logic [3:0] OFF_ALARM_NEG  = 4'h7;
  localparam logic [3:0] OFF_DIAG       = 4'h8;
  localparam logic [3:0] OFF_LIMIT_RAW  = 4'h9;
  localparam logic [3:0] OFF_REF_DONE   = 4'hA;

  // Field positions
  localparam int BIT_STROKE_BEFORE_REF = 5;
  localparam int BIT_ALARM_AFTER_OT    = 6;
  localparam int BIT_MODE_DEFAULT      = 5;
  localparam int BIT_IGNORE_HARD_LIMIT = 6;
  localparam int BIT_SINGLE_SWITCH     = 0;
  localparam int BIT_PANEL_ESTOP       = 1;
  localparam int BIT_IRQ_ESTOP         = 0;
  localparam int BIT_IRQ_OVERTRAVEL    = 1;
  localparam int BIT_DIAG_EST_INT      = 0;
  localparam int BIT_DIAG_EST_PANEL    = 1;
  localparam int BIT_DIAG_EST_ALARM    = 2;
  localparam int BIT_DIAG_MODE13       = 3;
  localparam int BIT_DIAG_RELEASE      = 4;
  localparam int BIT_AX5_POS           = 6;
  localparam int BIT_AX5_NEG           = 7;

  // Reset values
  localparam logic [7:0] RST_STROKE_CFG = 8'h00;
  localparam logic [7:0] RST_MODE_CFG   = 8'h00;
  localparam logic [7:0] RST_LIMIT_CFG  = 8'h00;
  localparam logic [1:0] RST_SWITCH_CFG = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK   = 2'h0;

endpackage

// file: otm_axis.sv
// One axis of overtravel supervision: latches a positive and a negative alarm.
// Assumes limit levels already mapped per direction, 1 meaning in range.
`timescale 1ns/1ns
module otm_axis (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Contacts, 1 = in range
  input  wire logic i_pos_ok,
  input  wire logic i_neg_ok,
  // Configuration
  input  wire logic i_single,
  input  wire logic i_check_en,
  input  wire logic i_ignore,
  input  wire logic i_after,
  // Motion
  input  wire logic i_cmd_pos_over,
  input  wire logic i_cmd_neg_over,
  input  wire logic i_move_pos,
  input  wire logic i_move_neg,
  input  wire logic i_release,
  // Alarms
  output logic      o_alarm_pos,
  output logic      o_alarm_neg
);

  typedef struct packed {
    logic alarm_pos;
    logic alarm_neg;
    logic dir_pos;
  } otm_axis_t;

  otm_axis_t st_reg;
  otm_axis_t st_next;
  logic      hit_pos;
  logic      hit_neg;

  always_comb begin
    st_next = st_reg;
    // A shared contact cannot tell direction, so the last commanded one is used
    if (i_move_pos) begin
      st_next.dir_pos = 1'b1;
    end else if (i_move_neg) begin
      st_next.dir_pos = 1'b0;
    end
    // Release held bypasses the contact so the axis can back off
    hit_pos = i_check_en & ~i_ignore & ~i_release & ~i_pos_ok
              & (~i_single | st_reg.dir_pos);
    hit_neg = i_check_en & ~i_ignore & ~i_release & ~i_neg_ok
              & (~i_single | ~st_reg.dir_pos);
    if (i_release & i_move_neg) begin
      st_next.alarm_pos = 1'b0;
    end
    if (i_release & i_move_pos) begin
      st_next.alarm_neg = 1'b0;
    end
    // Set wins over the release clear
    if (hit_pos | (i_check_en & ~i_after & i_cmd_pos_over)) begin
      st_next.alarm_pos = 1'b1;
    end
    if (hit_neg | (i_check_en & ~i_after & i_cmd_neg_over)) begin
      st_next.alarm_neg = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '{alarm_pos: 1'b0, alarm_neg: 1'b0, dir_pos: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_alarm_pos = st_reg.alarm_pos;
  assign o_alarm_neg = st_reg.alarm_neg;

  property p_open_contact;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_check_en && !i_ignore && !i_release && !i_single && !i_pos_ok) |=> o_alarm_pos;
  endproperty
  a_open_contact: assert property (p_open_contact) else $error("open contact not alarmed");

  property p_ignore;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_ignore && !i_cmd_neg_over && !o_alarm_neg) |=> !o_alarm_neg;
  endproperty
  a_ignore: assert property (p_ignore) else $error("hard limit not ignored");

  property p_no_check;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (!i_check_en && !o_alarm_pos) |=> !o_alarm_pos;
  endproperty
  a_no_check: assert property (p_no_check) else $error("alarm while unchecked");

  property p_before;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_check_en && !i_after && i_cmd_pos_over) |=> o_alarm_pos;
  endproperty
  a_before: assert property (p_before) else $error("early alarm missing");

  property p_release;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (o_alarm_pos && i_release && i_move_neg && !i_cmd_pos_over) |=> !o_alarm_pos;
  endproperty
  a_release: assert property (p_release) else $error("release did not clear");

endmodule

// file: otm_monitor.sv
// Overtravel and emergency stop monitor for a five-axis machining controller.
// Assumes synchronous contact inputs, a motion planner that reports jog
// directions and commands that would leave the stroke, and a plain register port.
// Operation
// - Two-switch mode: paired inputs, axis five upper
// - Config bit picks two or one switch
// - Single-switch mode: even bits, one per axis, none for axis five
// - Report axis alarm, block motion toward it
// - Reverse move with release held clears alarm
// - Stroke check before reference return is optional
// - Timing bit: alarm before or after overtravel
// - Ignore bit disregards hard limit alarms
// - Default bit picks mode after reset, clear
// - Stop input not one raises stop alarm
// - Stop input state readable as diagnostic
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module otm_monitor
  import otm_pkg::*;
#(
  parameter int ADDR_W = OTM_ADDR_W
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // Limit contacts and stop buttons
  input  wire logic [7:0]        i_limit_byte0,
  input  wire logic [7:0]        i_limit_byte5,
  input  wire logic              i_estop_integral,
  input  wire logic              i_estop_panel,
  input  wire logic              i_ot_release,
  // Motion planner
  input  wire logic [4:0]        i_move_pos,
  input  wire logic [4:0]        i_move_neg,
  input  wire logic [4:0]        i_cmd_pos_over,
  input  wire logic [4:0]        i_cmd_neg_over,
  input  wire logic [4:0]        i_ref_done,
  input  wire logic              i_state_clear,
  // Alarms and permissions
  output logic      [4:0]        o_allow_pos,
  output logic      [4:0]        o_allow_neg,
  output logic      [4:0]        o_alarm_pos,
  output logic      [4:0]        o_alarm_neg,
  output logic                   o_estop_alarm,
  output logic                   o_mode13,
  output logic                   o_irq
);

  if (ADDR_W < OTM_ADDR_W) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  typedef struct packed {
    logic [7:0] stroke_cfg;
    logic [7:0] mode_cfg;
    logic [7:0] limit_cfg;
    logic [1:0] switch_cfg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [4:0] ref_done;
    logic       estop_alarm;
    logic       mode13;
    logic       ot_any;
    logic [7:0] rdata;
  } otm_state_t;

  localparam otm_state_t ST_RST = '{
    stroke_cfg:  RST_STROKE_CFG,
    mode_cfg:    RST_MODE_CFG,
    limit_cfg:   RST_LIMIT_CFG,
    switch_cfg:  RST_SWITCH_CFG,
    irq_status:  2'h0,
    irq_mask:    RST_IRQ_MASK,
    ref_done:    5'h00,
    estop_alarm: 1'b0,
    mode13:      RST_MODE_CFG[BIT_MODE_DEFAULT],
    ot_any:      1'b0,
    rdata:       8'h00
  };

  otm_state_t st_reg;
  otm_state_t st_next;

  logic [4:0] pos_ok;
  logic [4:0] neg_ok;
  logic [4:0] check_en;
  logic [4:0] alarm_pos;
  logic [4:0] alarm_neg;
  logic       single;
  logic       estop_in;
  logic       any_move;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    addr_is = (a == ADDR_W'(off));
  endfunction

  assign single   = st_reg.switch_cfg[BIT_SINGLE_SWITCH];
  assign estop_in = st_reg.switch_cfg[BIT_PANEL_ESTOP] ? i_estop_panel : i_estop_integral;
  assign any_move = |{i_move_pos, i_move_neg};

  // Contact mapping per axis; a shared contact feeds both directions
  for (genvar k = 0; k < 4; k++) begin : g_map
    assign pos_ok[k] = i_limit_byte0[2*k];
    assign neg_ok[k] = single ? i_limit_byte0[2*k] : i_limit_byte0[2*k+1];
  end
  // Axis five has no shared contact, so in single mode it is never tripped
  assign pos_ok[4] = single | i_limit_byte5[BIT_AX5_POS];
  assign neg_ok[4] = single | i_limit_byte5[BIT_AX5_NEG];

  // Checking runs once referenced, or from power-on when so configured
  assign check_en = {5{st_reg.stroke_cfg[BIT_STROKE_BEFORE_REF]}} | st_reg.ref_done;

  for (genvar k = 0; k < OTM_AXES; k++) begin : g_axis
    otm_axis u_axis (
      .i_sys_clk      (i_sys_clk),
      .i_arst_n       (i_arst_n),
      .i_pos_ok       (pos_ok[k]),
      .i_neg_ok       (neg_ok[k]),
      .i_single       (single),
      .i_check_en     (check_en[k]),
      .i_ignore       (st_reg.limit_cfg[BIT_IGNORE_HARD_LIMIT]),
      .i_after        (st_reg.stroke_cfg[BIT_ALARM_AFTER_OT]),
      .i_cmd_pos_over (i_cmd_pos_over[k]),
      .i_cmd_neg_over (i_cmd_neg_over[k]),
      .i_move_pos     (i_move_pos[k]),
      .i_move_neg     (i_move_neg[k]),
      .i_release      (i_ot_release),
      .o_alarm_pos    (alarm_pos[k]),
      .o_alarm_neg    (alarm_neg[k])
    );
  end

  always_comb begin
    st_next = st_reg;
    st_next.ref_done = st_reg.ref_done | i_ref_done;
    if (i_wr) begin
      if (addr_is(i_addr, OFF_STROKE_CFG)) begin
        st_next.stroke_cfg = i_wdata;
      end
      if (addr_is(i_addr, OFF_MODE_CFG)) begin
        st_next.mode_cfg = i_wdata;
      end
      if (addr_is(i_addr, OFF_LIMIT_CFG)) begin
        st_next.limit_cfg = i_wdata;
      end
      if (addr_is(i_addr, OFF_SWITCH_CFG)) begin
        st_next.switch_cfg = i_wdata[1:0];
      end
      if (addr_is(i_addr, OFF_IRQ_MASK)) begin
        st_next.irq_mask = i_wdata[1:0];
      end
      if (addr_is(i_addr, OFF_IRQ_STATUS)) begin
        st_next.irq_status = st_reg.irq_status & ~i_wdata[1:0];
      end
    end
    // Stop alarm holds until the input is back and the operator backs off
    if (!estop_in) begin
      st_next.estop_alarm = 1'b1;
    end else if (i_ot_release && any_move) begin
      st_next.estop_alarm = 1'b0;
    end
    if (i_state_clear) begin
      st_next.mode13 = st_reg.mode_cfg[BIT_MODE_DEFAULT];
    end
    st_next.ot_any = |{alarm_pos, alarm_neg};
    // Event sets come after the write-one clear so a coincident event is kept
    if (st_next.estop_alarm && !st_reg.estop_alarm) begin
      st_next.irq_status[BIT_IRQ_ESTOP] = 1'b1;
    end
    if (st_next.ot_any && !st_reg.ot_any) begin
      st_next.irq_status[BIT_IRQ_OVERTRAVEL] = 1'b1;
    end
    st_next.rdata = 8'h00;
    if (i_rd) begin
      if (addr_is(i_addr, OFF_STROKE_CFG)) begin
        st_next.rdata = st_reg.stroke_cfg;
      end else if (addr_is(i_addr, OFF_MODE_CFG)) begin
        st_next.rdata = st_reg.mode_cfg;
      end else if (addr_is(i_addr, OFF_LIMIT_CFG)) begin
        st_next.rdata = st_reg.limit_cfg;
      end else if (addr_is(i_addr, OFF_SWITCH_CFG)) begin
        st_next.rdata = {6'h00, st_reg.switch_cfg};
      end else if (addr_is(i_addr, OFF_IRQ_STATUS)) begin
        st_next.rdata = {6'h00, st_reg.irq_status};
      end else if (addr_is(i_addr, OFF_IRQ_MASK)) begin
        st_next.rdata = {6'h00, st_reg.irq_mask};
      end else if (addr_is(i_addr, OFF_ALARM_POS)) begin
        st_next.rdata = {3'h0, alarm_pos};
      end else if (addr_is(i_addr, OFF_ALARM_NEG)) begin
        st_next.rdata = {3'h0, alarm_neg};
      end else if (addr_is(i_addr, OFF_DIAG)) begin
        st_next.rdata[BIT_DIAG_EST_INT]   = i_estop_integral;
        st_next.rdata[BIT_DIAG_EST_PANEL] = i_estop_panel;
        st_next.rdata[BIT_DIAG_EST_ALARM] = st_reg.estop_alarm;
        st_next.rdata[BIT_DIAG_MODE13]    = st_reg.mode13;
        st_next.rdata[BIT_DIAG_RELEASE]   = i_ot_release;
      end else if (addr_is(i_addr, OFF_LIMIT_RAW)) begin
        st_next.rdata = i_limit_byte0;
      end else if (addr_is(i_addr, OFF_REF_DONE)) begin
        st_next.rdata = {3'h0, st_reg.ref_done};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Stop alarm also freezes every axis, not just the tripped direction
  assign o_allow_pos   = ~alarm_pos & {5{~st_reg.estop_alarm}};
  assign o_allow_neg   = ~alarm_neg & {5{~st_reg.estop_alarm}};
  assign o_alarm_pos   = alarm_pos;
  assign o_alarm_neg   = alarm_neg;
  assign o_estop_alarm = st_reg.estop_alarm;
  assign o_mode13      = st_reg.mode13;
  assign o_rdata       = st_reg.rdata;
  assign o_irq         = |(st_reg.irq_status & st_reg.irq_mask);

  property p_shared_contact;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      single |-> (pos_ok[3:0] == neg_ok[3:0]) && pos_ok[4] && neg_ok[4];
  endproperty
  a_shared_contact: assert property (p_shared_contact) else $error("shared map wrong");

  property p_two_switch_map;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      !single |-> (neg_ok[1] == i_limit_byte0[3]) && (pos_ok[4] == i_limit_byte5[6]);
  endproperty
  a_two_switch_map: assert property (p_two_switch_map) else $error("pair map wrong");

  property p_block_motion;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      |alarm_pos |-> ((o_allow_pos & alarm_pos) == 5'h00);
  endproperty
  a_block_motion: assert property (p_block_motion) else $error("motion not blocked");

  property p_estop_raise;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      !estop_in |=> o_estop_alarm && (o_allow_neg == 5'h00);
  endproperty
  a_estop_raise: assert property (p_estop_raise) else $error("stop alarm missing");

  property p_mode_default;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      i_state_clear |=> o_mode13 == $past(st_reg.mode_cfg[BIT_MODE_DEFAULT]);
  endproperty
  a_mode_default: assert property (p_mode_default) else $error("mode not reloaded");

  property p_diag_read;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_rd && addr_is(i_addr, OFF_DIAG)) |=> o_rdata[0] == $past(i_estop_integral);
  endproperty
  a_diag_read: assert property (p_diag_read) else $error("diagnostic read wrong");

endmodule

// file: otm_switch_model.sv
// Normally closed limit contacts and stop buttons facing the monitor.
// Assumes the bench requests openings and presses just after clock edges.
`timescale 1ns/1ns
module otm_switch_model (
  // Clock
  input  wire logic       i_sys_clk,
  // Requests
  input  wire logic [4:0] i_open_pos,
  input  wire logic [4:0] i_open_neg,
  input  wire logic       i_single,
  input  wire logic       i_press_int,
  input  wire logic       i_press_panel,
  // Contacts
  output logic      [7:0] o_limit_byte0,
  output logic      [7:0] o_limit_byte5,
  output logic            o_estop_integral,
  output logic            o_estop_panel
);
  // Unwired inputs float, so they toggle rather than hold a level
  logic [7:0] float_reg = 8'h5A;
  always_ff @(posedge i_sys_clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_single) begin
        o_limit_byte0[2*k]   = ~(i_open_pos[k] | i_open_neg[k]);
        o_limit_byte0[2*k+1] = float_reg[k];
      end else begin
        o_limit_byte0[2*k]   = ~i_open_pos[k];
        o_limit_byte0[2*k+1] = ~i_open_neg[k];
      end
    end
    o_limit_byte5    = {~i_open_neg[4], ~i_open_pos[4], float_reg[5:0]};
    o_estop_integral = ~i_press_int;
    o_estop_panel    = ~i_press_panel;
  end
endmodule

// file: tb_overtravel_estop_monitor.sv
// Self-checking bench for the overtravel and stop monitor.
// Assumes the switch model on the contact side and a plain register port.
`timescale 1ns/1ns
module tb_overtravel_estop_monitor;
  import otm_pkg::*;
  logic       clk = 0, arst_n = 0, wr_s, rd_s, rel, sclr, sgl, p_int, p_pan;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, b0, b5, r, d;
  logic [4:0] mp, mn, cpo, cno, refd, op, on, al_p, al_n, ok_p, ok_n;
  logic       est_i, est_p, est_al, m13, irq;
  logic [9:0] e;
  int         n_errors = 0, check_count = 0, cycles = 0;
  logic [3:0] cfg_off [3] = '{OFF_STROKE_CFG, OFF_MODE_CFG, OFF_LIMIT_CFG};

  otm_switch_model u_otm_switch_model (.i_sys_clk(clk), .i_open_pos(op), .i_open_neg(on),
    .i_single(sgl), .i_press_int(p_int), .i_press_panel(p_pan), .o_limit_byte0(b0),
    .o_limit_byte5(b5), .o_estop_integral(est_i), .o_estop_panel(est_p));
  otm_monitor u_otm_monitor (.i_sys_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_limit_byte0(b0),
    .i_limit_byte5(b5), .i_estop_integral(est_i), .i_estop_panel(est_p),
    .i_ot_release(rel), .i_move_pos(mp), .i_move_neg(mn), .i_cmd_pos_over(cpo),
    .i_cmd_neg_over(cno), .i_ref_done(refd), .i_state_clear(sclr), .o_allow_pos(ok_p),
    .o_allow_neg(ok_n), .o_alarm_pos(al_p), .o_alarm_neg(al_n), .o_estop_alarm(est_al),
    .o_mode13(m13), .o_irq(irq));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      results();
    end
  end

  task automatic chk(input logic [11:0] x, input logic [11:0] g, input string w);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH t=%0t %s exp=%h got=%h", $time, w, x, g);
    end
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) {addr, wdata, wr_s} <= {a, v, 1'b1};
    @(posedge clk) wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) {addr, rd_s} <= {a, 1'b1};
    @(posedge clk) rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // Contacts close, then release is held through a minus and a plus jog
  task automatic clear_all();
    @(posedge clk) {op, on, cpo, cno, p_int, p_pan, rel, mn} <= {22'h0, 1'b1, 5'h1F};
    @(posedge clk) {mn, mp} <= {5'h00, 5'h1F};
    @(posedge clk) {mp, rel} <= 6'h00;
    settle();
  endtask
  // Expected latched alarms {neg, pos}; single switch alarms plus side only
  function automatic logic [9:0] model(input int p, input int n, input bit s, input bit en,
                                       input bit ign);
    if (!en || ign)
      return 10'h000;
    if (s)
      return {5'h00, 5'((p | n) & 15)};
    return {5'(n), 5'(p)};
  endfunction

  initial begin
    {addr, wdata, wr_s, rd_s, rel, sclr, sgl, p_int, p_pan} = '0;
    {mp, mn, cpo, cno, refd, op, on} = '0;
    void'($urandom(46395));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    chk(10'h3FF, {ok_n, ok_p}, "reset allow");
    chk(10'h000, {m13, est_al, irq}, "reset flags");
    foreach (cfg_off[i]) begin
      rd(cfg_off[i], r);
      chk(10'h000, r, "cfg reset");
      d = 8'($urandom);
      wr(cfg_off[i], d);
      rd(cfg_off[i], r);
      chk(d, r, "cfg rw");
    end
    wr(4'hB, 8'($urandom));
    rd(4'hB, r);
    chk(10'h000, r, "unmapped");
    wr(OFF_STROKE_CFG, 8'h20);
    wr(OFF_MODE_CFG, 8'h00);
    wr(OFF_LIMIT_CFG, 8'h00);
    $display("test registers done");
    for (int k = 0; k < 10; k++) begin
      @(posedge clk) {on, op} <= 10'h001 << k;
      settle();
      e = model(k < 5 ? 1 << k : 0, k < 5 ? 0 : 1 << (k - 5), 0, 1, 0);
      chk(e, {al_n, al_p}, "two-switch alarm");
      chk(10'(~e), {ok_n, ok_p}, "two-switch allow");
      rd(k < 5 ? OFF_ALARM_POS : OFF_ALARM_NEG, r);
      chk(k < 5 ? e[4:0] : e[9:5], r, "alarm reg");
      clear_all();
      chk(10'h000, {al_n, al_p}, "released");
    end
    $display("test two-switch done");
    wr(OFF_SWITCH_CFG, 8'h01);
    sgl <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) {on, op} <= k[0] ? 10'h020 << k : 10'h001 << k;
      settle();
      e = model(k[0] ? 0 : 1 << k, k[0] ? 1 << k : 0, 1, 1, 0);
      chk(e, {al_n, al_p}, "single alarm");
      clear_all();
    end
    wr(OFF_SWITCH_CFG, 8'h00);
    sgl <= 1'b0;
    $display("test single-switch done");
    wr(OFF_STROKE_CFG, 8'h00);
    @(posedge clk) op <= 5'h02;
    repeat (2) settle();
    chk(model(2, 0, 0, 0, 0), {al_n, al_p}, "no check before ref");
    @(posedge clk) refd <= 5'h02;
    @(posedge clk) refd <= 5'h00;
    repeat (2) settle();
    chk(model(2, 0, 0, 1, 0), {al_n, al_p}, "check after ref");
    clear_all();
    wr(OFF_STROKE_CFG, 8'h20);
    wr(OFF_LIMIT_CFG, 8'h40);
    @(posedge clk) on <= 5'h10;
    repeat (2) settle();
    chk(model(0, 16, 0, 1, 1), {al_n, al_p}, "ignore limit");
    clear_all();
    wr(OFF_LIMIT_CFG, 8'h00);
    $display("test gating done");
    for (int t = 0; t < 2; t++) begin
      wr(OFF_STROKE_CFG, t ? 8'h60 : 8'h20);
      @(posedge clk) {cno, cpo} <= 10'h104;
      repeat (2) settle();
      chk(t ? 10'h000 : 10'h104, {al_n, al_p}, "command over");
      clear_all();
    end
    $display("test timing done");
    wr(OFF_IRQ_MASK, 8'h01);
    for (int p = 0; p < 2; p++) begin
      wr(OFF_SWITCH_CFG, 8'(p << 1));
      @(posedge clk) {p_int, p_pan} <= p ? 2'b10 : 2'b01;
      repeat (2) settle();
      chk(10'h000, est_al, "unselected stop");
      @(posedge clk) {p_int, p_pan} <= 2'b11;
      repeat (2) settle();
      chk(12'h801, {est_al, ok_n, ok_p, irq}, "stop alarm");
      rd(OFF_DIAG, r);
      chk(10'h004, r, "diag");
      wr(OFF_IRQ_STATUS, 8'h01);
      #1 chk(10'h000, irq, "irq cleared");
      clear_all();
      chk(10'h3FF, {est_al, ok_n, ok_p}, "stop released");
    end
    wr(OFF_SWITCH_CFG, 8'h00);
    wr(OFF_IRQ_MASK, 8'h02);
    #1 chk(10'h001, irq, "sticky overtravel irq");
    wr(OFF_IRQ_STATUS, 8'h02);
    #1 chk(10'h000, irq, "overtravel irq cleared");
    $display("test stop and irq done");
    wr(OFF_MODE_CFG, 8'h20);
    settle();
    chk(10'h000, m13, "mode before clear");
    @(posedge clk) sclr <= 1'b1;
    @(posedge clk) sclr <= 1'b0;
    repeat (2) settle();
    chk(10'h001, m13, "mode after clear");
    $display("test mode done");
    results();
  end
endmodule
